/* File: hdl/ppie_defines.svh */
`ifndef PPIE_DEFINES_SVH
`define PPIE_DEFINES_SVH

// register byte offsets on the bus
`define PPIE_OFF_P2PU_LO 8'h00
`define PPIE_OFF_P2PU_HI 8'h04
`define PPIE_OFF_P3PU 8'h08
`define PPIE_OFF_P0PD 8'h0C
`define PPIE_OFF_P1PD 8'h10
`define PPIE_OFF_P2PD_LO 8'h14
`define PPIE_OFF_P2PD_HI 8'h18
`define PPIE_OFF_P3PD 8'h1C
`define PPIE_OFF_MIX 8'h20
`define PPIE_OFF_IE0 8'h24
`define PPIE_OFF_IE1 8'h28
`define PPIE_OFF_DIR 8'h2C

// reset values
`define PPIE_RST_PULL 8'h00
`define PPIE_RST_IE0 8'hFF
`define PPIE_RST_IE1 6'h3F
`define PPIE_RST_DIR 32'hFFFF_FFFF

// writable bits of the port 0 pull-down register
`define PPIE_P0PD_MASK 8'hF3

// two-bit resistor codes
`define PPIE_CODE_WEAK 2'h1
`define PPIE_CODE_STRONG 2'h2
`define PPIE_CODE_MID 2'h3
`define PPIE_CODE_RSVD 2'h3

// bit positions
`define PPIE_MIX_PD13 7
`define PPIE_MIX_PU13 6
`define PPIE_IE1_P35 3
`define PPIE_PIN13 11
`define PPIE_PIN35 29

`endif

/* File: hdl/ppie_pad_ctrl.sv */
`timescale 1ns/10ps
`include "ppie_defines.svh"
// Behaviour
// - port 2 pull-up code per pin: 00 off, 01 weak, 10 strong, 11 reserved
// - port 2 pull-up pins 0-3 low register, 4-7 high, reset zero
// - port 3 pull-up: pins 4,3 single bits 7,6; pins 2-0 two-bit codes
// - port 0 pull-down enables pins 7-4 and 1-0; bits 3,2 reserved
// - port 1 pull-down: bit n enables 10k pull-down on pin n
// - port 2 pull-down codes: 00 off, 01 10k, 10 500, 11 3.3k
// - port 3 pull-down: pins 4,3 single bits; pins 2-0 two-bit codes
// - combined register bits 7,6: strong pull-down and pull-up on port 1 pin 3
// - combined bits 5-3 pull-ups, 2-0 pull-downs on port 3 pins 7,6,5
// - first input enable register resets to ones; zero turns receiver off
// - first input enable maps to port 0 pins 7-4 and 1-0, port 1 pin 3, port 3 pin 0
// - second input enable has six bits reset one; bits 7,6 unimplemented
// - port 3 pin 5 input enable is inverted: one disables
// - pulls act only on input pins; direction one is input, reset one
module ppie_pad_ctrl
#(
   parameter int ADDR_W = 8
)
(
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [ADDR_W-1:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire ppie_pkg::ppie_word_t i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire ppie_pkg::ppie_pins_t i_pad_in,
   output logic [31:0] o_pu_weak,
   output logic [31:0] o_pu_strong,
   output logic [31:0] o_pd_weak,
   output logic [31:0] o_pd_strong,
   output logic [31:0] o_pd_mid,
   output logic [31:0] o_in_en,
   output logic [31:0] o_pin_data
);
   import ppie_pkg::*;

   initial
   begin
      if (ADDR_W < 8)
         $error("ADDR_W must be at least 8");
   end

   ppie_state_s r;
   ppie_state_s n;

   logic [63:0] pu_code;
   logic [63:0] pd_code;
   logic [31:0] pu_bit;
   logic [31:0] pd_bit;
   logic [31:0] ie_vec;
   logic hit;
   logic [7:0] offs;
   ppie_word_t rd;

   always_comb
   begin
      n = r;
      // bits above the eight decoded address bits must be zero to hit
      hit = ((i_address >> 8) == '0);
      offs = i_address[7:0];

      // per-pin two-bit codes, pin k at [2k+1:2k]; unused pins stay zero
      pu_code = '0;
      pd_code = '0;
      pu_code[32 +: 8] = r.p2pu_lo;
      pu_code[40 +: 8] = r.p2pu_hi;
      pu_code[48 +: 6] = r.p3pu[5:0];
      pd_code[32 +: 8] = r.p2pd_lo;
      pd_code[40 +: 8] = r.p2pd_hi;
      pd_code[48 +: 6] = r.p3pd[5:0];

      // single-bit 10k enables
      pu_bit = '0;
      pd_bit = '0;
      pu_bit[28] = r.p3pu[7];
      pu_bit[27] = r.p3pu[6];
      pu_bit[31:29] = r.mix[5:3];
      pd_bit[7:0] = r.p0pd & `PPIE_P0PD_MASK;
      pd_bit[15:8] = r.p1pd;
      pd_bit[28] = r.p3pd[7];
      pd_bit[27] = r.p3pd[6];
      pd_bit[31:29] = r.mix[2:0];

      // pins with no receiver control keep their input on
      ie_vec = '1;
      ie_vec[7:4] = r.ie0[7:4];
      ie_vec[1:0] = r.ie0[1:0];
      ie_vec[`PPIE_PIN13] = r.ie0[3];
      ie_vec[24] = r.ie0[2];
      ie_vec[31] = r.ie1[5];
      ie_vec[30] = r.ie1[4];
      ie_vec[`PPIE_PIN35] = ~r.ie1[`PPIE_IE1_P35];
      ie_vec[27] = r.ie1[2];
      ie_vec[15] = r.ie1[1];
      ie_vec[14] = r.ie1[0];

      // an output pin gets no pull at all, whatever the codes say
      for (int k = 0; k < 32; k++)
      begin
         n.pu_weak[k] = r.dir[k] & (pu_bit[k] | (pu_code[2*k +: 2] == `PPIE_CODE_WEAK));
         n.pu_strong[k] = r.dir[k] & (pu_code[2*k +: 2] == `PPIE_CODE_STRONG);
         n.pd_weak[k] = r.dir[k] & (pd_bit[k] | (pd_code[2*k +: 2] == `PPIE_CODE_WEAK));
         n.pd_strong[k] = r.dir[k] & (pd_code[2*k +: 2] == `PPIE_CODE_STRONG);
         n.pd_mid[k] = r.dir[k] & (pd_code[2*k +: 2] == `PPIE_CODE_MID);
      end
      n.pd_strong[`PPIE_PIN13] = r.dir[`PPIE_PIN13] & r.mix[`PPIE_MIX_PD13];
      n.pu_strong[`PPIE_PIN13] = r.dir[`PPIE_PIN13] & r.mix[`PPIE_MIX_PU13];
      n.in_en = ie_vec;
      // a floating analog level must not toggle logic behind a closed receiver
      n.pin_data = i_pad_in & ie_vec;

      // read mux; reserved and unimplemented bits read zero
      rd = '0;
      if (hit)
      begin
         unique case (offs)
            `PPIE_OFF_P2PU_LO: rd[7:0] = r.p2pu_lo;
            `PPIE_OFF_P2PU_HI: rd[7:0] = r.p2pu_hi;
            `PPIE_OFF_P3PU: rd[7:0] = r.p3pu;
            `PPIE_OFF_P0PD: rd[7:0] = r.p0pd;
            `PPIE_OFF_P1PD: rd[7:0] = r.p1pd;
            `PPIE_OFF_P2PD_LO: rd[7:0] = r.p2pd_lo;
            `PPIE_OFF_P2PD_HI: rd[7:0] = r.p2pd_hi;
            `PPIE_OFF_P3PD: rd[7:0] = r.p3pd;
            `PPIE_OFF_MIX: rd[7:0] = r.mix;
            `PPIE_OFF_IE0: rd[7:0] = r.ie0;
            `PPIE_OFF_IE1: rd[5:0] = r.ie1;
            `PPIE_OFF_DIR: rd = r.dir;
            default: rd = '0;
         endcase
      end

      // one wait cycle: data is loaded while waitrequest is high and
      // the write lands on the edge that sees waitrequest low
      if (r.waitreq)
      begin
         if (i_read || i_write)
         begin
            n.waitreq = 1'b0;
            n.rdata = i_read ? rd : '0;
         end
      end
      else
      begin
         n.waitreq = 1'b1;
         if (i_write && hit)
         begin
            if (i_byteenable[0])
            begin
               unique case (offs)
                  `PPIE_OFF_P2PU_LO: n.p2pu_lo = i_writedata[7:0];
                  `PPIE_OFF_P2PU_HI: n.p2pu_hi = i_writedata[7:0];
                  `PPIE_OFF_P3PU: n.p3pu = i_writedata[7:0];
                  `PPIE_OFF_P0PD: n.p0pd = i_writedata[7:0] & `PPIE_P0PD_MASK;
                  `PPIE_OFF_P1PD: n.p1pd = i_writedata[7:0];
                  `PPIE_OFF_P2PD_LO: n.p2pd_lo = i_writedata[7:0];
                  `PPIE_OFF_P2PD_HI: n.p2pd_hi = i_writedata[7:0];
                  `PPIE_OFF_P3PD: n.p3pd = i_writedata[7:0];
                  `PPIE_OFF_MIX: n.mix = i_writedata[7:0];
                  `PPIE_OFF_IE0: n.ie0 = i_writedata[7:0];
                  `PPIE_OFF_IE1: n.ie1 = i_writedata[5:0];
                  default: n.ie1 = r.ie1;
               endcase
            end
            if (offs == `PPIE_OFF_DIR)
            begin
               for (int b = 0; b < 4; b++)
               begin
                  if (i_byteenable[b])
                     n.dir[8*b +: 8] = i_writedata[8*b +: 8];
               end
            end
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         r <= '0;
         r.ie0 <= `PPIE_RST_IE0;
         r.ie1 <= `PPIE_RST_IE1;
         r.dir <= `PPIE_RST_DIR;
         r.waitreq <= 1'b1;
         r.in_en <= '1;
      end
      else
      begin
         r <= n;
      end
   end

   assign o_readdata = r.rdata;
   assign o_waitrequest = r.waitreq;
   assign o_pu_weak = r.pu_weak;
   assign o_pu_strong = r.pu_strong;
   assign o_pd_weak = r.pd_weak;
   assign o_pd_strong = r.pd_strong;
   assign o_pd_mid = r.pd_mid;
   assign o_in_en = r.in_en;
   assign o_pin_data = r.pin_data;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);

   sequence s_req_seen;
      (i_read || i_write) && o_waitrequest;
   endsequence

   sequence s_answer;
      !o_waitrequest ##1 o_waitrequest;
   endsequence

   // a write lands on the edge that samples waitrequest low
   sequence s_write_at(logic [7:0] off, logic lane);
      i_write && !o_waitrequest && hit && offs == off && lane;
   endsequence

   // a read is loaded while waitrequest is still high
   sequence s_read_at(logic [7:0] off);
      i_read && o_waitrequest && hit && offs == off;
   endsequence

   // pads still show reset levels on the first edge after release, so
   // the port 3 pin 5 inversion check and the pin data check skip that one edge
   sequence s_out_of_reset;
      $past(i_nrst);
   endsequence

   a_bus_one_wait: assert property (s_req_seen |=> s_answer)
      else $error("bus answer not one cycle after request");

   a_wait_idle: assert property (!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
      else $error("bus answered without a request");

   a_wait_short: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_p2_strong_pu: assert property (o_pu_strong[16] ==
      ($past(r.p2pu_lo[1:0]) == `PPIE_CODE_STRONG && $past(r.dir[16])))
      else $error("port 2 pin 0 strong pull-up wrong");

   a_p2_weak_pu: assert property (o_pu_weak[17] ==
      ($past(r.p2pu_lo[3:2]) == `PPIE_CODE_WEAK && $past(r.dir[17])))
      else $error("port 2 pin 1 weak pull-up wrong");

   // the reserved code must not fall through to either resistor
   a_p2_code_resv: assert property ($past(r.p2pu_lo[7:6]) == `PPIE_CODE_RSVD |->
      !o_pu_weak[19] && !o_pu_strong[19])
      else $error("reserved pull-up code drives a resistor");

   a_p2_high_pair: assert property (o_pu_weak[23] ==
      ($past(r.p2pu_hi[7:6]) == `PPIE_CODE_WEAK && $past(r.dir[23])))
      else $error("port 2 pin 7 weak pull-up wrong");

   a_p2_high_strong: assert property (o_pu_strong[22] ==
      ($past(r.p2pu_hi[5:4]) == `PPIE_CODE_STRONG && $past(r.dir[22])))
      else $error("port 2 pin 6 strong pull-up wrong");

   a_p3_single_pu: assert property (o_pu_weak[28] == ($past(r.p3pu[7]) && $past(r.dir[28])))
      else $error("port 3 pin 4 pull-up wrong");

   a_p3_single_pu3: assert property (o_pu_weak[27] ==
      ($past(r.p3pu[6]) && $past(r.dir[27])))
      else $error("port 3 pin 3 pull-up wrong");

   a_p3_code_pu: assert property (o_pu_strong[26] ==
      ($past(r.p3pu[5:4]) == `PPIE_CODE_STRONG && $past(r.dir[26])))
      else $error("port 3 pin 2 strong pull-up wrong");

   a_p0_reserved: assert property (!o_pd_weak[3] && !o_pd_weak[2] && r.p0pd[3:2] == 2'b00)
      else $error("port 0 reserved pull-down active");

   a_p0_pulldown: assert property (o_pd_weak[7] ==
      ($past(r.p0pd[7]) && $past(r.dir[7])))
      else $error("port 0 pin 7 pull-down wrong");

   a_p0_write_mask: assert property (s_write_at(`PPIE_OFF_P0PD, i_byteenable[0]) |=>
      r.p0pd == ($past(i_writedata[7:0]) & `PPIE_P0PD_MASK))
      else $error("port 0 pull-down write not masked");

   a_p1_pulldown: assert property (o_pd_weak[13] == ($past(r.p1pd[5]) && $past(r.dir[13])))
      else $error("port 1 pin 5 pull-down wrong");

   a_p1_write: assert property (s_write_at(`PPIE_OFF_P1PD, i_byteenable[0]) |=>
      r.p1pd == $past(i_writedata[7:0]))
      else $error("port 1 pull-down write lost");

   a_p1_lane_off: assert property (s_write_at(`PPIE_OFF_P1PD, !i_byteenable[0]) |=>
      $stable(r.p1pd))
      else $error("port 1 pull-down written with lane 0 off");

   a_p2_mid_pd: assert property (o_pd_mid[22] ==
      ($past(r.p2pd_hi[5:4]) == `PPIE_CODE_MID && $past(r.dir[22])))
      else $error("port 2 pin 6 3.3k pull-down wrong");

   a_p2_weak_pd: assert property (o_pd_weak[17] ==
      ($past(r.p2pd_lo[3:2]) == `PPIE_CODE_WEAK && $past(r.dir[17])))
      else $error("port 2 pin 1 weak pull-down wrong");

   a_p2_strong_pd: assert property (o_pd_strong[22] ==
      ($past(r.p2pd_hi[5:4]) == `PPIE_CODE_STRONG && $past(r.dir[22])))
      else $error("port 2 pin 6 strong pull-down wrong");

   a_p3_code_pd: assert property (o_pd_strong[26] ==
      ($past(r.p3pd[5:4]) == `PPIE_CODE_STRONG && $past(r.dir[26])))
      else $error("port 3 pin 2 strong pull-down wrong");

   a_p3_single_pd: assert property (o_pd_weak[28] ==
      ($past(r.p3pd[7]) && $past(r.dir[28])))
      else $error("port 3 pin 4 pull-down wrong");

   a_p3_mid_pd: assert property (o_pd_mid[24] ==
      ($past(r.p3pd[1:0]) == `PPIE_CODE_MID && $past(r.dir[24])))
      else $error("port 3 pin 0 3.3k pull-down wrong");

   a_p13_strong: assert property (o_pd_strong[11] == ($past(r.mix[7]) && $past(r.dir[11]))
      && o_pu_strong[11] == ($past(r.mix[6]) && $past(r.dir[11])))
      else $error("port 1 pin 3 strong pulls wrong");

   a_mix_readback: assert property (s_read_at(`PPIE_OFF_MIX) |=>
      o_readdata == {24'h00_0000, $past(r.mix)})
      else $error("combined pull register read wrong");

   a_p3_upper_pu: assert property (o_pu_weak[31] == ($past(r.mix[5]) && $past(r.dir[31])))
      else $error("port 3 pin 7 pull-up wrong");

   a_p3_upper_pd: assert property (o_pd_weak[29] ==
      ($past(r.mix[0]) && $past(r.dir[29])))
      else $error("port 3 pin 5 pull-down wrong");

   // pins on ports 0 to 2 with no receiver control must never lose their input
   a_free_inputs: assert property (o_in_en[23:16] == 8'hFF && o_in_en[13:12] == 2'h3
      && o_in_en[10:8] == 3'h7 && o_in_en[3:2] == 2'h3)
      else $error("uncontrolled receiver switched off");

   a_ie0_write: assert property (s_write_at(`PPIE_OFF_IE0, i_byteenable[0]) |=>
      r.ie0 == $past(i_writedata[7:0]))
      else $error("first input enable write lost");

   a_ie0_map: assert property (o_in_en[7] == $past(r.ie0[7]) && o_in_en[24] == $past(r.ie0[2]))
      else $error("first input enable mapping wrong");

   a_ie0_low: assert property (o_in_en[0] == $past(r.ie0[0])
      && o_in_en[1] == $past(r.ie0[1]) && o_in_en[11] == $past(r.ie0[3]))
      else $error("first input enable low bits mapped wrong");

   a_ie1_read: assert property ((i_read && o_waitrequest && offs == `PPIE_OFF_IE1 && hit)
      |=> o_readdata[7:6] == 2'b00)
      else $error("unimplemented input enable bits read nonzero");

   a_ie1_map: assert property (o_in_en[31] == $past(r.ie1[5])
      && o_in_en[27] == $past(r.ie1[2]) && o_in_en[15] == $past(r.ie1[1]))
      else $error("second input enable mapping wrong");

   a_ie1_write: assert property (s_write_at(`PPIE_OFF_IE1, i_byteenable[0]) |=>
      r.ie1 == $past(i_writedata[5:0]))
      else $error("second input enable write lost");

   a_p35_invert: assert property (s_out_of_reset |-> o_in_en[29] == !$past(r.ie1[3]))
      else $error("port 3 pin 5 input enable not inverted");

   a_output_nopull: assert property (($past(~r.dir) &
      (o_pu_weak | o_pu_strong | o_pd_weak | o_pd_strong | o_pd_mid)) == '0)
      else $error("pull active on output pin");

   a_dir_lane: assert property (s_write_at(`PPIE_OFF_DIR, i_byteenable[1]) |=>
      r.dir[15:8] == $past(i_writedata[15:8]))
      else $error("direction byte 1 write lost");

   a_data_gated: assert property ((o_pin_data & ~o_in_en) == '0)
      else $error("disabled input passes data");

   a_data_follow: assert property (s_out_of_reset |->
      o_pin_data == ($past(i_pad_in) & o_in_en))
      else $error("pin data does not follow the pad");

endmodule

/* File: hdl/ppie_pkg.sv */
package ppie_pkg;

   typedef logic [31:0] ppie_word_t;
   typedef logic [31:0] ppie_pins_t;
   typedef logic [7:0] ppie_byte_t;

   typedef struct packed {
      ppie_byte_t p2pu_lo;
      ppie_byte_t p2pu_hi;
      ppie_byte_t p3pu;
      ppie_byte_t p0pd;
      ppie_byte_t p1pd;
      ppie_byte_t p2pd_lo;
      ppie_byte_t p2pd_hi;
      ppie_byte_t p3pd;
      ppie_byte_t mix;
      ppie_byte_t ie0;
      logic [5:0] ie1;
      ppie_pins_t dir;
      logic waitreq;
      ppie_word_t rdata;
      ppie_pins_t pu_weak;
      ppie_pins_t pu_strong;
      ppie_pins_t pd_weak;
      ppie_pins_t pd_strong;
      ppie_pins_t pd_mid;
      ppie_pins_t in_en;
      ppie_pins_t pin_data;
   } ppie_state_s;

endpackage

/* File: verif/ppie_pad_ctrl_test.sv */
`timescale 1ns/10ps
`include "ppie_defines.svh"
module ppie_pad_ctrl_test;
   import ppie_pkg::*;
   logic i_core_clk;
   logic i_nrst;
   logic [7:0] i_address;
   logic i_read;
   logic i_write;
   logic [3:0] i_byteenable;
   ppie_word_t i_writedata;
   ppie_pins_t i_pad_in;
   logic o_waitrequest;
   logic [31:0] o_readdata, o_pu_weak, o_pu_strong, o_pd_weak, o_pd_strong, o_pd_mid;
   logic [31:0] o_in_en, o_pin_data, rd;
   int mismatches;
   int tests_run;
   localparam logic [7:0] OFFS [12] = '{`PPIE_OFF_P2PU_LO, `PPIE_OFF_P2PU_HI, `PPIE_OFF_P3PU,
      `PPIE_OFF_P0PD, `PPIE_OFF_P1PD, `PPIE_OFF_P2PD_LO, `PPIE_OFF_P2PD_HI, `PPIE_OFF_P3PD,
      `PPIE_OFF_MIX, `PPIE_OFF_IE0, `PPIE_OFF_IE1, `PPIE_OFF_DIR};
   localparam logic [31:0] RSTV [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h00FF, 32'h003F, 32'hFFFF_FFFF};
   localparam logic [31:0] FULV [12] = '{32'h00FF, 32'h00FF, 32'h00FF, 32'h00F3, 32'h00FF,
      32'h00FF, 32'h00FF, 32'h00FF, 32'h00FF, 32'h00FF, 32'h003F, 32'hFFFF_FFFF};
   // codes per pin 3..0 are 11,10,01,00 so every level shows up once
   localparam logic [7:0] CODA [9] = '{`PPIE_OFF_P2PU_LO, `PPIE_OFF_P2PU_HI, `PPIE_OFF_P3PU,
      `PPIE_OFF_P0PD, `PPIE_OFF_P1PD, `PPIE_OFF_P2PD_LO, `PPIE_OFF_P2PD_HI, `PPIE_OFF_P3PD,
      `PPIE_OFF_MIX};
   localparam logic [31:0] CODV [9] = '{32'h00E4, 32'h00E4, 32'h00E4, 32'h00FF, 32'h005A,
      32'h00E4, 32'h00E4, 32'h00E7, 32'h00AA};

   ppie_pad_ctrl i_ppie_pad_ctrl (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_address(i_address),
      .i_read(i_read),
      .i_write(i_write),
      .i_byteenable(i_byteenable),
      .i_writedata(i_writedata),
      .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest),
      .i_pad_in(i_pad_in),
      .o_pu_weak(o_pu_weak),
      .o_pu_strong(o_pu_strong),
      .o_pd_weak(o_pd_weak),
      .o_pd_strong(o_pd_strong),
      .o_pd_mid(o_pd_mid),
      .o_in_en(o_in_en),
      .o_pin_data(o_pin_data)
   );

   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held until waitrequest is sampled low; data taken at that edge
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      @(posedge i_core_clk);
      i_address <= a;
      i_write <= wr;
      i_read <= !wr;
      i_writedata <= d;
      i_byteenable <= be;
      do
         @(posedge i_core_clk);
      while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
   endtask

   // pad outputs trail the register by one edge
   task automatic settle();
      repeat (3) @(posedge i_core_clk);
      #1;
   endtask

   task automatic pads(input logic [31:0] uw, us, dw, ds, dm);
      check("pu_weak", o_pu_weak, uw);
      check("pu_strong", o_pu_strong, us);
      check("pd_weak", o_pd_weak, dw);
      check("pd_strong", o_pd_strong, ds);
      check("pd_mid", o_pd_mid, dm);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (5000) @(posedge i_core_clk);
      mismatches++;
      tally_and_finish();
   end

   initial
   begin
      i_nrst = 1'b0;
      i_address = 8'h00;
      i_read = 1'b0;
      i_write = 1'b0;
      i_byteenable = 4'hF;
      i_writedata = 32'h0;
      i_pad_in = 32'hFFFF_FFFF;
      mismatches = 0;
      tests_run = 0;
      repeat (2) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      settle();
      pads(32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
      check("in_en reset", o_in_en, 32'hDFFF_FFFF);
      check("pin_data reset", o_pin_data, 32'hDFFF_FFFF);
      check("waitrequest idle", o_waitrequest, 32'h0000_0001);
      for (int k = 0; k < 12; k++)
      begin
         access(1'b0, OFFS[k], 32'h0, 4'hF);
         check("reset value", rd, RSTV[k]);
      end
      $display("reset values done");
      for (int k = 0; k < 12; k++)
      begin
         access(1'b1, OFFS[k], 32'hFFFF_FFFF, 4'hF);
         access(1'b0, OFFS[k], 32'h0, 4'hF);
         check("readback", rd, FULV[k]);
      end
      access(1'b0, 8'h30, 32'h0, 4'hF);
      check("unmapped", rd, 32'h0);
      for (int k = 0; k < 9; k++)
         access(1'b1, CODA[k], CODV[k], 4'hF);
      access(1'b1, `PPIE_OFF_P1PD, 32'h0, 4'hE);
      access(1'b0, `PPIE_OFF_P1PD, 32'h0, 4'hF);
      check("lane0 off", rd, 32'h005A);
      $display("access kinds done");
      settle();
      pads(32'hBA22_0000, 32'h0444_0000, 32'h5A22_5AF3, 32'h0444_0800, 32'h0188_0000);
      // outputs on ports 1 to 3 must lose every pull
      access(1'b1, `PPIE_OFF_DIR, 32'h0000_00FF, 4'hF);
      settle();
      pads(32'h0, 32'h0, 32'h0000_00F3, 32'h0, 32'h0);
      access(1'b1, `PPIE_OFF_DIR, 32'hFFFF_FFFF, 4'hF);
      $display("pull decoding done");
      access(1'b1, `PPIE_OFF_IE0, 32'h0055, 4'hF);
      access(1'b1, `PPIE_OFF_IE1, 32'h00D5, 4'hF);
      access(1'b0, `PPIE_OFF_IE1, 32'h0, 4'hF);
      check("ie1 readback", rd, 32'h0015);
      settle();
      check("in_en", o_in_en, 32'h7FFF_775D);
      check("pin_data ones", o_pin_data, 32'h7FFF_775D);
      @(posedge i_core_clk);
      i_pad_in <= 32'hA5A5_A5A5;
      settle();
      check("pin_data mixed", o_pin_data, 32'h25A5_2505);
      $display("input enable done");
      tally_and_finish();
   end
endmodule
